// ### logic/clock_gate_ctrl.sv
// top of the clock gating block: register file, mode tracking, interrupts
// assumes: classic Wishbone master on REF_CLK_I; mode inputs and
// peripheral access strobes come from logic on the same clock
//
// Operation
// - deep-sleep gating register 0: 32 bits at 0x120 above 0x400F_E000.
// - a gating bit at one supplies the clock to its unit.
// - a gating bit at zero stops the clock of its unit.
// - an access to a unit whose clock is off ends in a bus fault.
// - reset clears every gating bit so all units start unclocked.
// - deep-sleep gating register 0 reads 0x00000040 after reset.
// - run, sleep and deep-sleep gating sets exist side by side.
// - sleep and deep-sleep sets apply only while auto gating is set.
// - bit 16 is the read-write adc 0 clock enable, reset zero.
// - bit 20 enables pwm and bit 3 the watchdog, both reset zero.
// - bits 31:21, 19:17, 15:4 and 2:0 are read-only and ignore writes.
//
// Register access over Wishbone is this design's own decision.
module clock_gate_ctrl
(
  input wire logic REF_CLK_I,          // system clock, 10 MHz
  input wire logic RST_N_I,            // async reset, active low
  input wire logic CYC_I,              // wishbone cycle
  input wire logic STB_I,              // wishbone strobe
  input wire logic WE_I,               // wishbone write
  input wire logic [31:0] ADR_I,       // wishbone byte address
  input wire logic [3:0] SEL_I,        // wishbone byte lanes
  input wire logic [31:0] DAT_I,       // wishbone write data
  output logic [31:0] DAT_O,           // wishbone read data
  output logic ACK_O,                  // wishbone acknowledge
  output logic ERR_O,                  // wishbone error, unmapped
  input wire logic SLEEP_I,            // processor in sleep
  input wire logic DEEP_SLEEP_I,       // processor in deep sleep
  input wire logic PERIPH_ACC_I,       // peripheral access strobe
  input wire logic [1:0] PERIPH_ID_I,  // peripheral addressed
  output logic PERIPH_ACK_O,           // access completed
  output logic PERIPH_FAULT_O,         // access faulted
  output logic PWM_CLK_EN_O,           // pwm clock enable
  output logic ADC0_CLK_EN_O,          // adc 0 clock enable
  output logic WDOG_CLK_EN_O,          // watchdog clock enable
  output logic IRQ_O                   // fault interrupt, level
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  cg_gate_if gate ();

  logic [2:0] run_units_reg;
  logic [2:0] sleep_units_reg;
  logic [2:0] deep_units_reg;
  logic acg_reg;
  cg_pkg::mode_e mode_reg;
  cg_pkg::mode_e mode_next;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_en_reg;
  logic [2:0] fault_evt;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;
  logic in_block;
  logic [11:0] ofs;
  logic mapped;
  logic wr_commit;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign in_block = ADR_I[31:12] == cg_pkg::SYSCTL_BASE[31:12];
  assign ofs = ADR_I[11:0];
  assign req = CYC_I && STB_I;

  always_comb
  begin
    mapped = 1'b1;
    rdata_next = cg_pkg::ZERO_WORD;
    unique case (ofs)
      cg_pkg::RUN_CFG_OFS:
      begin
        rdata_next[cg_pkg::ACG_BIT] = acg_reg;
      end
      cg_pkg::RUN_GATE_OFS: rdata_next = cg_pkg::word_of(run_units_reg);
      cg_pkg::SLEEP_GATE_OFS: rdata_next = cg_pkg::word_of(sleep_units_reg);
      // reserved bits read back as the fixed image
      cg_pkg::DEEP_GATE_OFS: rdata_next = cg_pkg::word_of(deep_units_reg);
      cg_pkg::IRQ_STAT_OFS: rdata_next = {29'h0000_0000, irq_stat_reg};
      cg_pkg::IRQ_CLR_OFS: rdata_next = cg_pkg::ZERO_WORD;
      cg_pkg::IRQ_EN_OFS: rdata_next = {29'h0000_0000, irq_en_reg};
      cg_pkg::GATE_STATE_OFS:
      begin
        rdata_next = {24'h00_0000, 1'b0, acg_reg, mode_reg, 1'b0,
                      gate.clk_en};
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
    if (!in_block || ofs[1:0] != 2'h0)
    begin
      mapped = 1'b0;
    end
  end

  // ****************************************************************
  // wishbone handshake
  // ****************************************************************
  // answer one cycle after the request; the write lands on the edge
  // at which the master samples the acknowledge
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= cg_pkg::ZERO_WORD;
    end
    else
    begin
      ack_reg <= req && mapped && !ack_reg && !err_reg;
      err_reg <= req && !mapped && !ack_reg && !err_reg;
      if (req && mapped && !ack_reg && !err_reg && !WE_I)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wr_commit = req && WE_I && ack_reg;
  assign ACK_O = ack_reg;
  assign ERR_O = err_reg;
  assign DAT_O = rdata_reg;

  // ****************************************************************
  // gating registers
  // ****************************************************************
  // only the three enable bits are stored; writes to reserved bits
  // are dropped on the floor
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      run_units_reg <= cg_pkg::UNITS_RESET;
      sleep_units_reg <= cg_pkg::UNITS_RESET;
      deep_units_reg <= cg_pkg::UNITS_RESET;
    end
    else if (wr_commit)
    begin
      if (ofs == cg_pkg::RUN_GATE_OFS)
      begin
        run_units_reg <= cg_pkg::units_of(cg_pkg::lanes(
          cg_pkg::word_of(run_units_reg), DAT_I, SEL_I));
      end
      if (ofs == cg_pkg::SLEEP_GATE_OFS)
      begin
        sleep_units_reg <= cg_pkg::units_of(cg_pkg::lanes(
          cg_pkg::word_of(sleep_units_reg), DAT_I, SEL_I));
      end
      if (ofs == cg_pkg::DEEP_GATE_OFS)
      begin
        // adc 0 at bit 16, pwm at bit 20, watchdog at bit 3
        deep_units_reg <= cg_pkg::units_of(cg_pkg::lanes(
          cg_pkg::word_of(deep_units_reg), DAT_I, SEL_I));
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      acg_reg <= cg_pkg::ACG_RESET;
    end
    else if (wr_commit && ofs == cg_pkg::RUN_CFG_OFS
             && SEL_I[cg_pkg::ACG_BIT / 8])
    begin
      acg_reg <= DAT_I[cg_pkg::ACG_BIT];
    end
  end

  // ****************************************************************
  // power mode tracking
  // ****************************************************************
  // deep sleep outranks sleep when both are raised
  always_comb
  begin
    if (DEEP_SLEEP_I)
    begin
      mode_next = cg_pkg::MODE_DEEP;
    end
    else if (SLEEP_I)
    begin
      mode_next = cg_pkg::MODE_SLEEP;
    end
    else
    begin
      mode_next = cg_pkg::MODE_RUN;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mode_reg <= cg_pkg::MODE_RUN;
    end
    else
    begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************************************
  // gating and fault check
  // ****************************************************************
  assign gate.run_units = run_units_reg;
  assign gate.sleep_units = sleep_units_reg;
  assign gate.deep_units = deep_units_reg;
  assign gate.auto_gate = acg_reg;
  assign gate.mode = mode_reg;

  gate_select u_select
  (
    .clk_i (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .gate (gate.sel)
  );

  fault_check u_check
  (
    .clk_i (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .gate (gate.chk),
    .acc_i (PERIPH_ACC_I),
    .id_i (PERIPH_ID_I),
    .ok_o (PERIPH_ACK_O),
    .fault_o (PERIPH_FAULT_O),
    .fault_evt_o (fault_evt)
  );

  assign PWM_CLK_EN_O = gate.clk_en[cg_pkg::UNIT_PWM];
  assign ADC0_CLK_EN_O = gate.clk_en[cg_pkg::UNIT_ADC0];
  assign WDOG_CLK_EN_O = gate.clk_en[cg_pkg::UNIT_WDOG];

  // ****************************************************************
  // fault interrupts
  // ****************************************************************
  // a fault in the cycle of its clear stays set
  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (wr_commit && ofs == cg_pkg::IRQ_CLR_OFS && SEL_I[0])
    begin
      irq_stat_next = irq_stat_reg & ~DAT_I[2:0];
    end
    irq_stat_next = irq_stat_next | fault_evt;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      irq_stat_reg <= cg_pkg::IRQ_RESET;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      irq_en_reg <= cg_pkg::IRQ_RESET;
    end
    else if (wr_commit && ofs == cg_pkg::IRQ_EN_OFS && SEL_I[0])
    begin
      irq_en_reg <= DAT_I[2:0];
    end
  end

  assign IRQ_O = |(irq_stat_reg & irq_en_reg);

endmodule : clock_gate_ctrl

// ### include/cg_pkg.sv
// package: constants and helpers of the deep-sleep clock gating block
// assumes: one 10 MHz system clock, classic Wishbone register access
package cg_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;
  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATE_OFS = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h120;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h180;
  localparam logic [11:0] IRQ_CLR_OFS = 12'h184;
  localparam logic [11:0] IRQ_EN_OFS = 12'h188;
  localparam logic [11:0] GATE_STATE_OFS = 12'h18C;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int NUM_UNITS = 3;
  localparam int PWM_BIT = 20;
  localparam int ADC0_BIT = 16;
  localparam int WDOG_BIT = 3;
  localparam int ACG_BIT = 27;
  localparam logic [31:0] GATE_RESET = 32'h0000_0040;
  localparam logic [31:0] GATE_RW_MASK = 32'h0011_0008;
  localparam logic [2:0] UNITS_RESET = 3'h0;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic ACG_RESET = 1'b0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // unit index: 0 pwm, 1 adc0, 2 watchdog
  localparam logic [1:0] UNIT_PWM = 2'h0;
  localparam logic [1:0] UNIT_ADC0 = 2'h1;
  localparam logic [1:0] UNIT_WDOG = 2'h2;

  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} mode_e;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] units_of(input logic [31:0] w);
    units_of = {w[WDOG_BIT], w[ADC0_BIT], w[PWM_BIT]};
  endfunction : units_of

  function automatic logic [31:0] word_of(input logic [2:0] u);
    logic [31:0] w;
    w = GATE_RESET & ~GATE_RW_MASK;
    w[PWM_BIT] = u[0];
    w[ADC0_BIT] = u[1];
    w[WDOG_BIT] = u[2];
    word_of = w;
  endfunction : word_of

  function automatic logic [31:0] lanes(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] sel);
    logic [31:0] w;
    w = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        w[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    lanes = w;
  endfunction : lanes

endpackage : cg_pkg

// ### include/cg_gate_if.sv
// interface: gating sets, mode and resulting clock enables
// assumes: all members on the system clock
interface cg_gate_if;
  logic [2:0] run_units;
  logic [2:0] sleep_units;
  logic [2:0] deep_units;
  logic auto_gate;
  cg_pkg::mode_e mode;
  logic [2:0] clk_en;

  modport sel (input run_units, input sleep_units, input deep_units,
               input auto_gate, input mode, output clk_en);
  modport chk (input clk_en);
  modport ctl (output run_units, output sleep_units, output deep_units,
               output auto_gate, output mode, input clk_en);
endinterface : cg_gate_if

// ### logic/gate_select.sv
// picks the gating set that applies in the present power mode
// assumes: mode and sets come from the register block on the same clock
module gate_select
(
  input wire logic clk_i,     // system clock
  input wire logic rst_n_i,   // async reset, active low
  cg_gate_if.sel gate         // sets in, enables out
);

  logic [2:0] clk_en_next;
  logic [2:0] clk_en_reg;

  always_comb
  begin
    clk_en_next = gate.run_units;
    if (gate.auto_gate)
    begin
      unique case (gate.mode)
        cg_pkg::MODE_RUN: clk_en_next = gate.run_units;
        cg_pkg::MODE_SLEEP: clk_en_next = gate.sleep_units;
        cg_pkg::MODE_DEEP: clk_en_next = gate.deep_units;
        default: clk_en_next = gate.run_units;
      endcase
    end
    // without auto gating the run set stays in force
  end

  // registered so the enables never glitch
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clk_en_reg <= cg_pkg::UNITS_RESET;
    end
    else
    begin
      clk_en_reg <= clk_en_next;
    end
  end

  assign gate.clk_en = clk_en_reg;

endmodule : gate_select

// ### logic/fault_check.sv
// answers peripheral accesses: normal completion or bus fault
// assumes: access strobe and unit id come from the same clock domain
module fault_check
(
  input wire logic clk_i,        // system clock
  input wire logic rst_n_i,      // async reset, active low
  cg_gate_if.chk gate,           // current clock enables
  input wire logic acc_i,        // one-cycle access strobe
  input wire logic [1:0] id_i,   // target unit
  output logic ok_o,             // normal completion pulse
  output logic fault_o,          // bus fault pulse
  output logic [2:0] fault_evt_o // per unit fault pulse
);

  logic clocked;

  // an id past the last unit has no clock at all
  assign clocked = (id_i < 2'(cg_pkg::NUM_UNITS)) && gate.clk_en[id_i];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ok_o <= 1'b0;
      fault_o <= 1'b0;
      fault_evt_o <= 3'h0;
    end
    else
    begin
      ok_o <= acc_i && clocked;
      fault_o <= acc_i && !clocked;
      fault_evt_o <= 3'h0;
      if (acc_i && !clocked && id_i < 2'(cg_pkg::NUM_UNITS))
      begin
        fault_evt_o[id_i] <= 1'b1;
      end
    end
  end

endmodule : fault_check

// ### bench/clock_gate_ctrl_assertions.sv
// checker: bus answers, peripheral answers and clock enables
// assumes: bound to clock_gate_ctrl, one clock domain
module clock_gate_ctrl_check
(
  input wire logic REF_CLK_I,      // system clock
  input wire logic RST_N_I,        // async reset, active low
  input wire logic CYC_I,          // cycle
  input wire logic STB_I,          // strobe
  input wire logic WE_I,           // write
  input wire logic ACK_O,          // acknowledge
  input wire logic ERR_O,          // error
  input wire logic SLEEP_I,        // sleep mode
  input wire logic DEEP_SLEEP_I,   // deep sleep mode
  input wire logic PERIPH_ACC_I,   // access strobe
  input wire logic [1:0] PERIPH_ID_I, // unit addressed
  input wire logic PERIPH_ACK_O,   // access done
  input wire logic PERIPH_FAULT_O, // access faulted
  input wire logic PWM_CLK_EN_O,   // pwm enable
  input wire logic ADC0_CLK_EN_O,  // adc 0 enable
  input wire logic WDOG_CLK_EN_O   // watchdog enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // properties
  // ****************************************************************
  logic en_sel;
  logic en_any;
  always_comb
  begin
    case (PERIPH_ID_I)
      2'h0: en_sel = PWM_CLK_EN_O;
      2'h1: en_sel = ADC0_CLK_EN_O;
      2'h2: en_sel = WDOG_CLK_EN_O;
      default: en_sel = 1'b0;
    endcase
  end
  assign en_any = PWM_CLK_EN_O || ADC0_CLK_EN_O || WDOG_CLK_EN_O;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_bus_answer_next: assert property (
    CYC_I && STB_I && !ACK_O && !ERR_O |=> ACK_O ^ ERR_O)
    else $error("bus request not answered");
  a_answer_one_pulse: assert property (
    ACK_O || ERR_O |=> !ACK_O && !ERR_O)
    else $error("bus answer too long");
  a_bus_quiet_idle: assert property (
    !(CYC_I && STB_I) |=> !ACK_O && !ERR_O)
    else $error("answer without request");
  a_fault_when_gated: assert property (
    PERIPH_ACC_I && !en_sel |=> PERIPH_FAULT_O && !PERIPH_ACK_O)
    else $error("no fault");
  a_done_when_clocked: assert property (
    PERIPH_ACC_I && en_sel |=> PERIPH_ACK_O && !PERIPH_FAULT_O)
    else $error("no done");
  a_periph_quiet: assert property (
    !PERIPH_ACC_I |=> !PERIPH_ACK_O && !PERIPH_FAULT_O)
    else $error("stray answer");
  a_units_off_reset: assert property (
    $rose(RST_N_I) |-> !en_any)
    else $error("unit clocked after reset");
  a_enable_has_cause: assert property (
    $rose(en_any) |-> $past(ACK_O && WE_I, 2)
    || ($past(SLEEP_I, 2) != $past(SLEEP_I, 3))
    || ($past(DEEP_SLEEP_I, 2) != $past(DEEP_SLEEP_I, 3)))
    else $error("enable rose without cause");
  c_fault: cover property (PERIPH_FAULT_O);
  c_done: cover property (PERIPH_ACK_O);
  c_error: cover property (ERR_O);
endmodule : clock_gate_ctrl_check

bind clock_gate_ctrl clock_gate_ctrl_check chk (.REF_CLK_I(REF_CLK_I),
  .RST_N_I(RST_N_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ACK_O(ACK_O), .ERR_O(ERR_O), .SLEEP_I(SLEEP_I),
  .DEEP_SLEEP_I(DEEP_SLEEP_I), .PERIPH_ACC_I(PERIPH_ACC_I),
  .PERIPH_ID_I(PERIPH_ID_I), .PERIPH_ACK_O(PERIPH_ACK_O),
  .PERIPH_FAULT_O(PERIPH_FAULT_O), .PWM_CLK_EN_O(PWM_CLK_EN_O),
  .ADC0_CLK_EN_O(ADC0_CLK_EN_O), .WDOG_CLK_EN_O(WDOG_CLK_EN_O));

// ### bench/wb_master.sv
// partner: classic wishbone master standing in for processor software
// assumes: slave answers on the same clock
module wb_master
(
  input wire logic clk_i,          // system clock
  input wire logic ack_i,          // acknowledge
  input wire logic err_i,          // error
  input wire logic [31:0] dat_i,   // read data
  output logic cyc_o,              // cycle
  output logic stb_o,              // strobe
  output logic we_o,               // write
  output logic [31:0] adr_o,       // byte address
  output logic [3:0] sel_o,        // byte lanes
  output logic [31:0] dat_o        // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 32'h0000_0000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  task automatic xfer(input logic we, input logic [11:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= cg_pkg::SYSCTL_BASE + {20'h0_0000, ofs};
    sel_o <= 4'hF;
    dat_o <= wd;
    do @(posedge clk_i); while (!(ack_i || err_i));
    rd = dat_i;
    err = err_i;
    // released lines show garbage, not the last value
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~adr_o;
    dat_o <= ~wd;
    sel_o <= 4'h0;
  endtask : xfer
endmodule : wb_master

// ### bench/test_clock_gate_ctrl.sv
// testbench: registers, gating sets, faults and interrupt of the block
// assumes: wb_master partner, checker bound to the design
module test_clock_gate_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n, cyc, stb, we, ack, err, slp, deep, acc, pack, pfault;
  logic pwm_en, adc_en, wdg_en, irq, e;
  logic [31:0] adr, dat_w, dat_r, rd;
  logic [3:0] sel;
  logic [1:0] id;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  wb_master bfm (.clk_i(clk), .ack_i(ack), .err_i(err), .dat_i(dat_r),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(dat_w));
  clock_gate_ctrl uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w),
    .DAT_O(dat_r), .ACK_O(ack), .ERR_O(err), .SLEEP_I(slp),
    .DEEP_SLEEP_I(deep), .PERIPH_ACC_I(acc), .PERIPH_ID_I(id),
    .PERIPH_ACK_O(pack), .PERIPH_FAULT_O(pfault), .PWM_CLK_EN_O(pwm_en),
    .ADC0_CLK_EN_O(adc_en), .WDOG_CLK_EN_O(wdg_en), .IRQ_O(irq));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic acc_bus(input logic w, input logic [11:0] o,
                         input logic [31:0] d, input logic [31:0] x);
    bfm.xfer(w, o, d, rd, e);
    check("bus error", 32'h0, {31'h0, e});
    if (!w)
      check("read data", x, rd);
  endtask : acc_bus
  task automatic units(input logic [2:0] x);
    repeat (3) @(posedge clk);
    check("enables", {29'h0, x}, {29'h0, wdg_en, adc_en, pwm_en});
  endtask : units
  task automatic poke(input logic [1:0] u, input logic flt);
    @(posedge clk);
    acc <= 1'b1;
    id <= u;
    @(posedge clk);
    acc <= 1'b0;
    @(posedge clk);
    check("fault", {31'h0, flt}, {31'h0, pfault});
    check("done", {31'h0, !flt}, {31'h0, pack});
  endtask : poke
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    acc_bus(1'b0, cg_pkg::DEEP_GATE_OFS, 32'h0, 32'h0000_0040);
    units(3'h0);
    for (int u = 0; u < 3; u++)
      poke(u[1:0], 1'b1);
    poke(2'h3, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_gating();
    acc_bus(1'b1, cg_pkg::RUN_GATE_OFS, 32'hFFFF_FFFF, 32'h0);
    acc_bus(1'b0, cg_pkg::RUN_GATE_OFS, 32'h0, 32'h0011_0048);
    units(3'h7);
    poke(2'h1, 1'b0);
    acc_bus(1'b1, cg_pkg::DEEP_GATE_OFS, 32'hFFEF_FFF7, 32'h0);
    acc_bus(1'b0, cg_pkg::DEEP_GATE_OFS, 32'h0, 32'h0001_0040);
    deep <= 1'b1;
    units(3'h7);
    acc_bus(1'b1, cg_pkg::RUN_CFG_OFS, 32'h0800_0000, 32'h0);
    units(3'h2);
    acc_bus(1'b0, cg_pkg::GATE_STATE_OFS, 32'h0, 32'h0000_0062);
    poke(2'h0, 1'b1);
    poke(2'h1, 1'b0);
    acc_bus(1'b1, cg_pkg::DEEP_GATE_OFS, 32'h0010_0008, 32'h0);
    units(3'h5);
    acc_bus(1'b1, cg_pkg::SLEEP_GATE_OFS, 32'h0001_0000, 32'h0);
    deep <= 1'b0;
    slp <= 1'b1;
    units(3'h2);
    slp <= 1'b0;
    units(3'h7);
    $display("test gating done");
  endtask : t_gating
  task automatic t_irq();
    acc_bus(1'b0, cg_pkg::IRQ_STAT_OFS, 32'h0, 32'h0000_0007);
    check("irq masked", 32'h0, {31'h0, irq});
    acc_bus(1'b1, cg_pkg::IRQ_EN_OFS, 32'h0000_0007, 32'h0);
    @(posedge clk);
    check("irq raised", 32'h1, {31'h0, irq});
    acc_bus(1'b1, cg_pkg::IRQ_CLR_OFS, 32'h0000_0007, 32'h0);
    acc_bus(1'b0, cg_pkg::IRQ_STAT_OFS, 32'h0, 32'h0);
    check("irq cleared", 32'h0, {31'h0, irq});
    bfm.xfer(1'b0, 12'h004, 32'h0, rd, e);
    check("unmapped error", 32'h1, {31'h0, e});
    bfm.xfer(1'b0, 12'h122, 32'h0, rd, e);
    check("misaligned error", 32'h1, {31'h0, e});
    $display("test interrupt done");
  endtask : t_irq
  // hang guard: whole run needs about a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    slp = 1'b0;
    deep = 1'b0;
    acc = 1'b0;
    id = 2'h3;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_gating();
    t_irq();
    summarize();
  end
endmodule : test_clock_gate_ctrl
